// File: logic/ldd_consts.vh
// Constants for the LED dimming driver core
`ifndef LDD_CONSTS_VH
`define LDD_CONSTS_VH
// ****************************************
// Timing
// ****************************************
`define LDD_CLK_PS 5000
`define LDD_OSC_PS 125000
`define LDD_TICK_CYC (`LDD_OSC_PS / `LDD_CLK_PS)
`define LDD_FILT_NS 50
`define LDD_FILT_CYC ((`LDD_FILT_NS * 1000) / `LDD_CLK_PS)
`define LDD_BLINK_PRE 8
// ****************************************
// Register indices (byte address is index * 4)
// ****************************************
`define LDD_R_MODE 6'd0
`define LDD_R_GRP_DUTY 6'd1
`define LDD_R_GRP_FREQ 6'd2
`define LDD_R_IREF 6'd3
`define LDD_R_DELAY 6'd4
`define LDD_R_GRP_ADDR 6'd5
`define LDD_R_SUB1 6'd6
`define LDD_R_SUB2 6'd7
`define LDD_R_SUB3 6'd8
`define LDD_R_STATUS 6'd9
`define LDD_R_OPEN 6'd10
`define LDD_R_SHORT 6'd11
`define LDD_R_BRIGHT0 6'd12
`define LDD_R_STATE0 6'd36
`define LDD_NUM_CFG 42
// ****************************************
// Fields
// ****************************************
`define LDD_F_BLINK 0
`define LDD_F_ON_ACK 1
`define LDD_F_GRP_EN 4
`define LDD_F_SUB1_EN 5
`define LDD_F_SUB2_EN 6
`define LDD_F_SUB3_EN 7
`define LDD_ST_OFF 2'd0
`define LDD_ST_ON 2'd1
`define LDD_ST_IND 2'd2
`define LDD_ST_GRP 2'd3
// ****************************************
// Reset values
// ****************************************
`define LDD_MODE_RST 8'h20
`define LDD_GRP_DUTY_RST 8'hff
`define LDD_GRP_ADDR_RST 8'he0
`define LDD_SUB1_RST 8'hb6
`define LDD_SUB2_RST 8'hb8
`define LDD_SUB3_RST 8'hba
`define LDD_ADDR_BASE 7'h01
`define LDD_GCALL 8'h00
`define LDD_BUS_RESET_CALL_DATA 8'h06
`endif

// File: logic/ldd_core.v
// LED dimming driver core: PWM engines, serial target, register bank
`timescale 1ns/1ps
`include "ldd_consts.vh"
// Operation
// - Each of 24 outputs has its own 8-bit PWM at 31.25 kHz.
// - Brightness has 256 linear steps, 0 to 99.6 percent, reset fully off.
// - Shared group PWM dims at 122 Hz; duty resets to maximum.
// - Blink mode period programmable from 15 Hz to 16.8 s, duty adjustable.
// - Per output state: off, on, individual PWM, individual plus group.
// - Programmable per-channel delay staggers output turn-on instants.
// - Serial writes apply at each acknowledge or all at stop; stop default.
// - Active-low output enable input gates all outputs at once.
// - Answers group and three sub addresses, each enabled by software.
// - One sub address defaults to a value identifying a 24-channel part.
// - Software reset call reinitialises everything like power-on reset.
// - Open, short and overtemperature conditions held in readable flags.
// - Overtemperature disables all output drive.
// - PWM and blink timing derives from an internal 8 MHz time base.
// - Three five-level address inputs select one of 125 addresses.
// - An 8-bit code sets the peak output current.
// - Serial clock and data are filtered against short pulses.
// - Outputs stay off and glitch free from reset until configured.
// - Address inputs sampled only after reset, then ignored.
module ldd_core (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output reg sda_oe_o,
   input wire output_enable_n_i,
   input wire [8:0] addr_level_i,
   input wire [23:0] open_det_i,
   input wire [23:0] short_det_i,
   input wire overtemp_i,
   output reg [23:0] sink_output_o,
   output reg [7:0] iref_code_o
);

   // ****************************************
   // Reset
   // ****************************************
   reg soft_rst;
   wire srst = rst_i | soft_rst;

   // ****************************************
   // Input synchronisers and filters
   // ****************************************
   wire [51:0] raw = {scl_i, sda_i, output_enable_n_i, overtemp_i,
                      open_det_i, short_det_i};
   reg [51:0] s1;
   reg [51:0] s2;
   reg [51:0] s3;
   reg [51:0] flt;
   always @(posedge clk_i) begin
      if (srst) begin
         s1 <= 52'he000000000000;
         s2 <= 52'he000000000000;
         s3 <= 52'he000000000000;
         flt <= 52'he000000000000;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         // A change is accepted once the last two stages agree
         flt <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & flt);
      end
   end
   wire oe_n_f = flt[49];
   wire ot_f = flt[48];
   wire [23:0] open_f = flt[47:24];
   wire [23:0] short_f = flt[23:0];

   // Spike filter on the serial lines
   wire [1:0] lin;
   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1) begin : gflt
         reg q;
         reg [3:0] c;
         always @(posedge clk_i) begin
            if (srst) begin
               q <= 1'b1;
               c <= 4'h0;
            end else if (flt[50 + k] == q) begin
               c <= 4'h0;
            end else if (c == `LDD_FILT_CYC - 1) begin
               q <= flt[50 + k];
               c <= 4'h0;
            end else begin
               c <= c + 4'h1;
            end
         end
         assign lin[k] = q;
      end
   endgenerate
   reg [1:0] lin_d;
   always @(posedge clk_i) begin
      if (srst) begin
         lin_d <= 2'b11;
      end else begin
         lin_d <= lin;
      end
   end
   wire scl_rise = lin[1] & ~lin_d[1];
   wire scl_fall = ~lin[1] & lin_d[1];
   wire bus_start = lin[1] & lin_d[1] & lin_d[0] & ~lin[0];
   wire bus_stop = lin[1] & lin_d[1] & ~lin_d[0] & lin[0];

   // ****************************************
   // Target address capture
   // ****************************************
   reg [6:0] own_addr;
   reg cap_pend;
   wire [2:0] lv0 = (addr_level_i[2:0] > 3'd4) ? 3'd4 : addr_level_i[2:0];
   wire [2:0] lv1 = (addr_level_i[5:3] > 3'd4) ? 3'd4 : addr_level_i[5:3];
   wire [2:0] lv2 = (addr_level_i[8:6] > 3'd4) ? 3'd4 : addr_level_i[8:6];
   wire [6:0] addr_idx = {2'b00, lv2} * 7'd25 + {4'h0, lv1} * 7'd5
                         + {4'h0, lv0};
   always @(posedge clk_i) begin
      if (srst) begin
         own_addr <= `LDD_ADDR_BASE;
         cap_pend <= 1'b1;
      end else if (cap_pend) begin
         own_addr <= `LDD_ADDR_BASE + addr_idx;
         cap_pend <= 1'b0;
      end
   end

   // ****************************************
   // Register bank
   // ****************************************
   reg [7:0] cfg [0:`LDD_NUM_CFG-1];
   reg [7:0] stage [0:`LDD_NUM_CFG-1];
   reg [`LDD_NUM_CFG-1:0] dirty;
   integer i;

   function [7:0] rst_val;
      input [5:0] ix;
      begin
         case (ix)
            `LDD_R_MODE: rst_val = `LDD_MODE_RST;
            `LDD_R_GRP_DUTY: rst_val = `LDD_GRP_DUTY_RST;
            `LDD_R_GRP_ADDR: rst_val = `LDD_GRP_ADDR_RST;
            `LDD_R_SUB1: rst_val = `LDD_SUB1_RST;
            `LDD_R_SUB2: rst_val = `LDD_SUB2_RST;
            `LDD_R_SUB3: rst_val = `LDD_SUB3_RST;
            default: rst_val = 8'h00;
         endcase
      end
   endfunction

   function writable;
      input [5:0] ix;
      begin
         writable = (ix < `LDD_NUM_CFG) && (ix != `LDD_R_STATUS)
                    && (ix != `LDD_R_OPEN) && (ix != `LDD_R_SHORT);
      end
   endfunction

   wire [7:0] mode_r = cfg[`LDD_R_MODE];
   wire on_ack = mode_r[`LDD_F_ON_ACK];

   // ****************************************
   // Serial target
   // ****************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_PTR = 3'd2;
   localparam ST_DATA = 3'd3;
   localparam ST_GCALL = 3'd4;
   reg [2:0] ist;
   reg [3:0] bcnt;
   reg [7:0] shreg;
   reg in_ack;
   reg [5:0] ptr;
   reg bus_reset_call_pend;

   wire byte_done = scl_fall & ~in_ack & (bcnt == 4'd8) & (ist != ST_IDLE);
   wire [6:0] ra = shreg[7:1];
   wire amatch = ~shreg[0] & ((ra == own_addr)
      | (mode_r[`LDD_F_GRP_EN] & (ra == cfg[`LDD_R_GRP_ADDR][7:1]))
      | (mode_r[`LDD_F_SUB1_EN] & (ra == cfg[`LDD_R_SUB1][7:1]))
      | (mode_r[`LDD_F_SUB2_EN] & (ra == cfg[`LDD_R_SUB2][7:1]))
      | (mode_r[`LDD_F_SUB3_EN] & (ra == cfg[`LDD_R_SUB3][7:1])));
   wire i2c_wr = byte_done & (ist == ST_DATA) & writable(ptr);
   wire commit_all = bus_stop & (ist != ST_IDLE) & ~on_ack;

   always @(posedge clk_i) begin
      if (srst) begin
         ist <= ST_IDLE;
         bcnt <= 4'h0;
         shreg <= 8'h00;
         in_ack <= 1'b0;
         sda_oe_o <= 1'b0;
         ptr <= 6'h00;
         bus_reset_call_pend <= 1'b0;
      end else if (bus_start) begin
         ist <= ST_ADDR;
         bcnt <= 4'h0;
         in_ack <= 1'b0;
         sda_oe_o <= 1'b0;
         bus_reset_call_pend <= 1'b0;
      end else if (bus_stop) begin
         ist <= ST_IDLE;
         in_ack <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (scl_rise && ist != ST_IDLE && !in_ack) begin
         shreg <= {shreg[6:0], lin[0]};
         bcnt <= bcnt + 4'h1;
      end else if (scl_fall && in_ack) begin
         in_ack <= 1'b0;
         sda_oe_o <= 1'b0;
         bcnt <= 4'h0;
      end else if (byte_done) begin
         case (ist)
            ST_ADDR: begin
               if (amatch) begin
                  ist <= ST_PTR;
                  in_ack <= 1'b1;
                  sda_oe_o <= 1'b1;
               end else if (shreg == `LDD_GCALL) begin
                  ist <= ST_GCALL;
                  in_ack <= 1'b1;
                  sda_oe_o <= 1'b1;
               end else begin
                  ist <= ST_IDLE;
               end
            end
            ST_PTR: begin
               ptr <= shreg[5:0];
               ist <= ST_DATA;
               in_ack <= 1'b1;
               sda_oe_o <= 1'b1;
            end
            ST_DATA: begin
               ptr <= ptr + 6'h01;
               in_ack <= 1'b1;
               sda_oe_o <= 1'b1;
            end
            ST_GCALL: begin
               if (shreg == `LDD_BUS_RESET_CALL_DATA) begin
                  bus_reset_call_pend <= 1'b1;
                  in_ack <= 1'b1;
                  sda_oe_o <= 1'b1;
               end
               ist <= ST_IDLE;
            end
            default: ist <= ST_IDLE;
         endcase
      end
   end
   assign sda_o = 1'b0;

   // Software reset fires at the stop so the call itself completes cleanly
   always @(posedge clk_i) begin
      if (rst_i) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= bus_stop & bus_reset_call_pend & ~soft_rst;
      end
   end

   // ****************************************
   // Wishbone slave
   // ****************************************
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [5:0] widx = wb_adr_i[7:2];
   wire wb_wr = wb_req & wb_we_i;
   wire [23:0] lane = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always @(posedge clk_i) begin
      if (srst) begin
         for (i = 0; i < `LDD_NUM_CFG; i = i + 1) begin
            cfg[i] <= rst_val(i[5:0]);
            stage[i] <= 8'h00;
         end
         dirty <= {`LDD_NUM_CFG{1'b0}};
      end else begin
         if (commit_all) begin
            for (i = 0; i < `LDD_NUM_CFG; i = i + 1) begin
               if (dirty[i]) begin
                  cfg[i] <= stage[i];
               end
            end
            dirty <= {`LDD_NUM_CFG{1'b0}};
         end
         if (i2c_wr) begin
            if (on_ack) begin
               cfg[ptr] <= shreg;
            end else begin
               stage[ptr] <= shreg;
               dirty[ptr] <= 1'b1;
            end
         end
         // Bus writes apply at once and win over a same-cycle serial write
         if (wb_wr && wb_sel_i[0] && writable(widx)) begin
            cfg[widx] <= wb_dat_i[7:0];
         end
      end
   end

   // Error flags: sticky, write one to clear, a new event beats the clear
   reg [23:0] open_flg;
   reg [23:0] short_flg;
   reg ot_stk;
   wire [23:0] active;
   always @(posedge clk_i) begin
      if (srst) begin
         open_flg <= 24'h000000;
         short_flg <= 24'h000000;
         ot_stk <= 1'b0;
      end else begin
         open_flg <= (open_flg & ~((wb_wr && widx == `LDD_R_OPEN) ?
                     wb_dat_i[23:0] & lane : 24'h000000))
                     | (open_f & active);
         short_flg <= (short_flg & ~((wb_wr && widx == `LDD_R_SHORT) ?
                      wb_dat_i[23:0] & lane : 24'h000000))
                      | (short_f & active);
         ot_stk <= (ot_stk & ~(wb_wr && widx == `LDD_R_STATUS
                    && wb_sel_i[0] && wb_dat_i[1])) | ot_f;
      end
   end

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (writable(widx)) begin
         rd_mux = {24'h000000, cfg[widx]};
      end else if (widx == `LDD_R_STATUS) begin
         rd_mux = {17'h00000, own_addr, 6'h00, ot_stk, ot_f};
      end else if (widx == `LDD_R_OPEN) begin
         rd_mux = {8'h00, open_flg};
      end else if (widx == `LDD_R_SHORT) begin
         rd_mux = {8'h00, short_flg};
      end
   end

   always @(posedge clk_i) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // ****************************************
   // Time base and PWM counters
   // ****************************************
   reg [4:0] tcnt;
   reg [7:0] pwm_cnt;
   reg [7:0] grp_cnt;
   reg [10:0] pre;
   wire tick = (tcnt == `LDD_TICK_CYC - 1);
   wire wrap = tick & (pwm_cnt == 8'hff);
   wire [10:0] pre_lim = {cfg[`LDD_R_GRP_FREQ], 3'b111};
   wire blink = mode_r[`LDD_F_BLINK];
   wire grp_step = wrap & (~blink | (pre == pre_lim));
   always @(posedge clk_i) begin
      if (srst) begin
         tcnt <= 5'h00;
         pwm_cnt <= 8'h00;
         grp_cnt <= 8'h00;
         pre <= 11'h000;
      end else begin
         tcnt <= tick ? 5'h00 : tcnt + 5'h01;
         if (tick) begin
            pwm_cnt <= pwm_cnt + 8'h01;
         end
         // Blink step is (freq + 1) * 8 individual periods long
         if (wrap) begin
            pre <= (~blink | (pre == pre_lim)) ? 11'h000 : pre + 11'h001;
         end
         if (grp_step) begin
            grp_cnt <= grp_cnt + 8'h01;
         end
      end
   end
   wire grp_on = grp_cnt < cfg[`LDD_R_GRP_DUTY];

   // ****************************************
   // Channel outputs
   // ****************************************
   wire [23:0] ch_on;
   genvar g;
   generate
      for (g = 0; g < 24; g = g + 1) begin : gch
         localparam [4:0] IDX = g;
         wire [12:0] off = cfg[`LDD_R_DELAY] * IDX;
         wire [7:0] phase = pwm_cnt + off[7:0];
         wire [7:0] st_r = cfg[`LDD_R_STATE0 + g / 4];
         wire [1:0] mode = st_r[2 * (g % 4) +: 2];
         wire ind = phase < cfg[`LDD_R_BRIGHT0 + g];
         assign ch_on[g] = (mode == `LDD_ST_ON)
                           | ((mode == `LDD_ST_IND) & ind)
                           | ((mode == `LDD_ST_GRP) & ind & grp_on);
         assign active[g] = (mode != `LDD_ST_OFF);
      end
   endgenerate

   wire en_all = ~oe_n_f & ~ot_f;
   always @(posedge clk_i) begin
      if (srst) begin
         sink_output_o <= 24'h000000;
         iref_code_o <= 8'h00;
      end else begin
         sink_output_o <= ch_on & {24{en_all}};
         iref_code_o <= cfg[`LDD_R_IREF];
      end
   end

endmodule // ldd_core

// File: tb/ldd_core_chk.sv
// Port checker for the LED dimming driver core
`timescale 1ns/1ps
`include "ldd_consts.vh"
module ldd_core_chk (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire scl_i,
   input wire sda_oe_o,
   input wire output_enable_n_i,
   input wire overtemp_i,
   input wire [23:0] sink_output_o,
   input wire [7:0] iref_code_o
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   sequence iref_wr;
      take && wb_we_i && wb_sel_i[0] && wb_adr_i == {`LDD_R_IREF, 2'b00};
   endsequence
   sequence stat_rd;
      take && !wb_we_i && wb_adr_i == {`LDD_R_STATUS, 2'b00};
   endsequence
   sequence ack_rise;
      $rose(sda_oe_o);
   endsequence
   chk_ack_on_take: assert property (take |=> wb_ack_o)
      else $error("bus ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(take))
      else $error("bus ack without request");
   chk_oe_gates: assert property (
      output_enable_n_i [*8] |=> sink_output_o == 24'h0)
      else $error("outputs on while enable high");
   chk_hot_off: assert property (
      overtemp_i [*8] |=> sink_output_o == 24'h0)
      else $error("outputs on while overheated");
   chk_reset_off: assert property ($fell(rst_i) |->
      sink_output_o == 24'h0 && iref_code_o == 8'h00 && !sda_oe_o)
      else $error("outputs not cleared by reset");
   chk_iref_copy: assert property (
      iref_wr |-> ##3 iref_code_o == $past(wb_dat_i[7:0], 3))
      else $error("current code not following write");
   chk_hot_status: assert property (
      overtemp_i [*8] ##0 stat_rd |=> wb_dat_o[0])
      else $error("overtemp flag not readable");
   chk_ack_scl_low: assert property (
      ack_rise |-> !scl_i && $past(scl_i, 8) == 1'b0)
      else $error("serial ack outside clock low");
   chk_ack_holds: assert property (
      ack_rise |=> (sda_oe_o && !scl_i) [*6])
      else $error("serial ack dropped early");
endmodule // ldd_core_chk
bind ldd_core ldd_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
   .sda_oe_o(sda_oe_o), .output_enable_n_i(output_enable_n_i),
   .overtemp_i(overtemp_i), .sink_output_o(sink_output_o),
   .iref_code_o(iref_code_o));

// File: tb/ldd_core_tb.sv
// Testbench for the LED dimming driver core
`timescale 1ns/1ps
`include "ldd_consts.vh"
module ldd_core_tb;
   // ****
   // Signals and instances
   // ****
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, oe_n = 1'b0, hot = 1'b0, ok;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rd;
   logic [8:0] lvl = {3'h2, 3'h1, 3'h3};
   logic [23:0] opn = 24'h0, sht = 24'h0;
   logic [6:0] a0;
   logic [7:0] rv [0:8] = '{`LDD_MODE_RST, `LDD_GRP_DUTY_RST, 8'h00,
      8'h00, 8'h00, `LDD_GRP_ADDR_RST, `LDD_SUB1_RST, `LDD_SUB2_RST,
      `LDD_SUB3_RST};
   wire [31:0] dat_o;
   wire [23:0] sink;
   wire [7:0] iref;
   wire ack, oe, sda_o, scl, sda_low;
   wire sda_line = ~(sda_low | (oe & ~sda_o));
   int n_mismatch = 0, total_checks = 0, hi, x;
   always #2.5 clk_i = ~clk_i;
   ldd_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(oe),
      .output_enable_n_i(oe_n), .addr_level_i(lvl), .open_det_i(opn),
      .short_det_i(sht), .overtemp_i(hot), .sink_output_o(sink),
      .iref_code_o(iref));
   ldd_i2c_host host_u (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
   // ****
   // Tasks
   // ****
   function logic [7:0] ra(input logic [5:0] i);
      return {i, 2'b00};
   endfunction
   function logic [6:0] own(input logic [8:0] l);
      return `LDD_ADDR_BASE + 7'd25 * l[8:6] + 7'd5 * l[5:3] + l[2:0];
   endfunction
   task chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wait_c(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Holds the request until ack is sampled, then releases for a cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         n_mismatch++;
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask
   // One full modulator period, so duty counts come out exact
   task count(input int a, b);
      hi = 0;
      x = 0;
      repeat (256 * `LDD_TICK_CYC) begin
         @(posedge clk_i);
         hi += sink[a];
         x += sink[a] ^ sink[b];
      end
   endtask
   // ****
   // Tests
   // ****
   initial begin
      #450000;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      wait_c(20);
      rst_i <= 1'b0;
      wait_c(2);
      for (int i = 0; i < 9; i++)
         rdc(ra(i[5:0]), 32'hffffffff, {24'h0, rv[i]}, "rst");
      rdc(ra(`LDD_R_BRIGHT0), 32'hff, 32'h0, "bright");
      chk("sink", sink, 32'h0);
      wb(1'b1, ra(6'd42), 32'hff);
      rdc(ra(6'd42), 32'hffffffff, 32'h0, "unmapped");
      a0 = own(lvl);
      rdc(ra(`LDD_R_STATUS), 32'h7f00, {17'h0, a0, 8'h0}, "own");
      lvl <= 9'h004;
      wait_c(10);
      rdc(ra(`LDD_R_STATUS), 32'h7f00, {17'h0, a0, 8'h0}, "own");
      wb(1'b1, ra(`LDD_R_STATE0), 32'h01);
      wait_c(10);
      chk("on", sink[1:0], 32'h1);
      oe_n <= 1'b1;
      wait_c(10);
      chk("gate", sink, 32'h0);
      oe_n <= 1'b0;
      hot <= 1'b1;
      wait_c(10);
      chk("hot", sink, 32'h0);
      rdc(ra(`LDD_R_STATUS), 32'h3, 32'h3, "hot");
      hot <= 1'b0;
      opn <= 24'h1;
      sht <= 24'h1;
      wait_c(10);
      rdc(ra(`LDD_R_STATUS), 32'h3, 32'h2, "sticky");
      rdc(ra(`LDD_R_OPEN), 32'h1, 32'h1, "open");
      rdc(ra(`LDD_R_SHORT), 32'h1, 32'h1, "short");
      opn <= 24'h0;
      sht <= 24'h0;
      // Let the cleared fault inputs pass the synchroniser before W1C
      wait_c(10);
      wb(1'b1, ra(`LDD_R_STATUS), 32'h2);
      wb(1'b1, ra(`LDD_R_OPEN), 32'h1);
      wb(1'b1, ra(`LDD_R_SHORT), 32'h1);
      rdc(ra(`LDD_R_STATUS), 32'h3, 32'h0, "clr");
      rdc(ra(`LDD_R_OPEN), 32'h1, 32'h0, "clr");
      rdc(ra(`LDD_R_SHORT), 32'h1, 32'h0, "clr");
      wb(1'b1, ra(`LDD_R_BRIGHT0 + 6'd2), 32'h40);
      wb(1'b1, ra(`LDD_R_BRIGHT0 + 6'd3), 32'h40);
      wb(1'b1, ra(`LDD_R_STATE0), 32'ha1);
      wait_c(10);
      count(2, 3);
      chk("duty", hi, `LDD_TICK_CYC * 32'h40);
      chk("skew", x, 32'h0);
      wb(1'b1, ra(`LDD_R_DELAY), 32'h10);
      wait_c(10);
      count(2, 3);
      chk("duty", hi, `LDD_TICK_CYC * 32'h40);
      chk("skew", x, `LDD_TICK_CYC * 32'h20);
      wb(1'b1, ra(`LDD_R_BRIGHT0 + 6'd4), 32'hff);
      wb(1'b1, ra(`LDD_R_STATE0 + 6'd1), 32'h02);
      wait_c(10);
      count(4, 4);
      chk("full", hi, `LDD_TICK_CYC * 32'hff);
      wb(1'b1, ra(`LDD_R_GRP_DUTY), 32'h00);
      wb(1'b1, ra(`LDD_R_STATE0 + 6'd1), 32'h03);
      wait_c(10);
      count(4, 4);
      chk("group", hi, 32'h0);
      host_u.xfer({a0, 1'b0}, 8'h03, 8'h5a, 1'b0, ok);
      wait_c(20);
      chk("ack", ok, 32'h1);
      chk("staged", iref, 32'h0);
      host_u.stop_c;
      wait_c(20);
      chk("stop", iref, 32'h5a);
      wb(1'b1, ra(`LDD_R_MODE), 32'h22);
      host_u.xfer({a0, 1'b0}, 8'h03, 8'ha5, 1'b0, ok);
      wait_c(20);
      chk("byack", iref, 32'ha5);
      host_u.stop_c;
      host_u.xfer(`LDD_SUB1_RST, 8'h03, 8'h33, 1'b1, ok);
      wait_c(20);
      chk("sub", {ok, iref}, 32'h133);
      wb(1'b1, ra(`LDD_R_MODE), 32'h02);
      host_u.xfer(`LDD_SUB1_RST, 8'h03, 8'h44, 1'b1, ok);
      wait_c(20);
      chk("suboff", {ok, iref}, 32'h033);
      wb(1'b1, ra(`LDD_R_MODE), 32'h12);
      host_u.xfer(`LDD_GRP_ADDR_RST, 8'h03, 8'h55, 1'b1, ok);
      wait_c(20);
      chk("grp", {ok, iref}, 32'h155);
      host_u.bus_reset_call;
      wait_c(20);
      chk("bus_reset_call", {sink, iref}, 32'h0);
      rdc(ra(`LDD_R_MODE), 32'hff, `LDD_MODE_RST, "mode");
      rdc(ra(`LDD_R_STATUS), 32'h7f00, {17'h0, own(lvl), 8'h0}, "own");
      give_verdict;
   end
endmodule // ldd_core_tb

// File: tb/ldd_i2c_host.sv
// Serial bus controller model that writes into the driver
`timescale 1ns/1ps
`include "ldd_consts.vh"
module ldd_i2c_host #(
   parameter int Q = 100
) (
   input wire sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // ****
   // Frame tasks
   // ****
   // Phase step kept longer than the input spike filter
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic start_c;
      sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic stop_c;
      sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         #Q scl_o = 1'b1;
         #(2 * Q) scl_o = 1'b0;
         #Q;
      end
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q ack = ~sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic xfer(input logic [7:0] a, p, d, input logic stop,
      output logic ok);
      logic k1, k2, k3;
      start_c;
      send(a, k1);
      send(p, k2);
      send(d, k3);
      ok = k1 & k2 & k3;
      if (stop)
         stop_c;
   endtask
   task automatic bus_reset_call;
      logic k;
      start_c;
      send(`LDD_GCALL, k);
      send(`LDD_BUS_RESET_CALL_DATA, k);
      stop_c;
   endtask
endmodule // ldd_i2c_host
